// [switch_port_lane_config.sv]
`timescale 1ns/1ps
module switch_port_lane_config (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Strap pins
  input  wire logic [1:0]   station0_width_strap,
  input  wire logic [1:0]   station4_width_strap,
  input  wire logic [1:0]   station5_width_strap,
  input  wire logic [1:0]   vswitch_count_strap,
  // Management register port, host and I2C side
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  input  wire logic [11:0]  reg_addr,
  input  wire logic [31:0]  reg_wdata,
  output logic [31:0]       reg_rdata,
  output logic              reg_rvalid,
  // Serial EEPROM loader
  input  wire logic         eeprom_wr,
  input  wire logic [11:0]  eeprom_addr,
  input  wire logic [31:0]  eeprom_wdata,
  // Link side, pins
  input  wire logic [47:0]  lane_ok,
  input  wire logic [59:0]  partner_width,
  input  wire logic [11:0]  train_req,
  input  wire logic [11:0]  gen2_capable,
  // Upstream device number assignment
  input  wire logic         dev_assign_valid,
  input  wire logic [4:0]   dev_assign_num,
  // Port status
  output logic [11:0]       port_enable,
  output logic [11:0]       port_visible,
  output logic [11:0]       link_up,
  output logic [59:0]       link_width,
  output logic [11:0]       lane_reversed,
  output logic [11:0]       link_gen2,
  output logic [59:0]       dev_num
);

  localparam int NP = lane_cfg_pkg::NUM_PORTS;
  localparam int NS = lane_cfg_pkg::STATIONS;
  localparam int NV = lane_cfg_pkg::NUM_VS;

  typedef struct packed {
    lane_cfg_pkg::strap_t strap_s1;
    lane_cfg_pkg::strap_t strap_s2;
    logic [47:0]          lane_s1;
    logic [47:0]          lane_s2;
    logic [59:0]          pw_s1;
    logic [59:0]          pw_s2;
    logic [11:0]          req_s1;
    logic [11:0]          req_s2;
    logic [11:0]          g2_s1;
    logic [11:0]          g2_s2;
    logic [1:0]           init_cnt;
    logic                 loaded;
    logic [31:0]          port_cfg;
    logic [3:0][8:0]      ups;
    logic [3:0][23:0]     member;
    logic [4:0]           up_dev;
    logic [31:0]          rdata;
    logic                 rvalid;
    logic [11:0]          en;
    logic [11:0]          vis;
    logic [11:0]          gen2;
    logic [11:0][4:0]     dev;
  } top_t;

  top_t               s_r;
  top_t               s_nxt;
  logic [2:0][3:0]      map_en;
  logic [2:0][3:0][4:0] map_w;
  logic [2:0][3:0][3:0] map_b;
  logic [11:0]          tr_up;
  logic [11:0]          tr_rev;
  logic [11:0][4:0]     tr_w;

  // --------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------
  // One word per switch in a four-word block; returns hit and index
  function automatic logic [2:0] vs_hit(input logic [11:0] addr, input logic [11:0] base);
    vs_hit = {(addr[11:4] == base[11:4]) && (addr[1:0] == 2'h0), addr[3:2]};
  endfunction : vs_hit

  function automatic logic [31:0] reg_read(input top_t s, input logic [11:0] addr);
    logic [2:0] hu;
    logic [2:0] hm;
    hu = vs_hit(addr, lane_cfg_pkg::OFS_VS_UP);
    hm = vs_hit(addr, lane_cfg_pkg::OFS_VS_MEMBER);
    reg_read = 32'h0000_0000;
    if (addr == lane_cfg_pkg::OFS_PORT_CFG) reg_read = s.port_cfg;
    else if (hu[2])                         reg_read = {23'h0, s.ups[hu[1:0]]};
    else if (hm[2])                         reg_read = {8'h00, s.member[hm[1:0]]};
  endfunction : reg_read

  // --------------------------------------------------------------
  // Station lane maps
  // --------------------------------------------------------------
  generate
    for (genvar st = 0; st < NS; st++) begin : g_stn
      lane_map_if lm ();
      assign lm.code = s_r.port_cfg[lane_cfg_pkg::STN_CFG_LSB[st] +: 2];
      station_lane_map u_map (
        .bus (lm.map)
      );
      assign map_en[st] = lm.en;
      assign map_w[st]  = lm.width;
      assign map_b[st]  = lm.base;
    end
  endgenerate

  // --------------------------------------------------------------
  // Per-port link training
  // --------------------------------------------------------------
  generate
    for (genvar k = 0; k < NP; k++) begin : g_port
      localparam int ST = k / lane_cfg_pkg::PORTS_PER_STN;
      localparam int Q  = k % lane_cfg_pkg::PORTS_PER_STN;
      logic [15:0] local_lanes;
      // Only lanes of the port's own station reach its trainer
      assign local_lanes = s_r.lane_s2[ST * lane_cfg_pkg::LANES_PER_STN +: 16] >> map_b[ST][Q];
      port_link_trainer u_train (
        .clk           (clk),
        .rst           (rst),
        .enable        (s_r.loaded && map_en[ST][Q]),
        .start         (s_r.req_s2[k]),
        .prog_width    (map_w[ST][Q]),
        .partner_width (s_r.pw_s2[k*5 +: 5]),
        .lanes         (local_lanes),
        .link_up       (tr_up[k]),
        .link_width    (tr_w[k]),
        .reversed      (tr_rev[k])
      );
    end
  endgenerate

  // --------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------
  logic        wr_en;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [2:0]  hit_up;
  logic [2:0]  hit_mem;
  logic        is_up;
  logic        in_vs;
  logic [4:0]  pn;

  always_comb begin
    s_nxt = s_r;
    is_up = 1'b0;
    in_vs = 1'b0;
    pn    = 5'h00;
    // Two-flop synchronisers for everything arriving on pins
    s_nxt.strap_s1 = {vswitch_count_strap, station5_width_strap,
                      station4_width_strap, station0_width_strap};
    s_nxt.strap_s2 = s_r.strap_s1;
    s_nxt.lane_s1  = lane_ok;
    s_nxt.lane_s2  = s_r.lane_s1;
    s_nxt.pw_s1    = partner_width;
    s_nxt.pw_s2    = s_r.pw_s1;
    s_nxt.req_s1   = train_req;
    s_nxt.req_s2   = s_r.req_s1;
    s_nxt.g2_s1    = gen2_capable;
    s_nxt.g2_s2    = s_r.g2_s1;

    // EEPROM has priority over the host when both write at once
    wr_en   = eeprom_wr || reg_wr;
    wr_addr = eeprom_wr ? eeprom_addr : reg_addr;
    wr_data = eeprom_wr ? eeprom_wdata : reg_wdata;
    hit_up  = vs_hit(wr_addr, lane_cfg_pkg::OFS_VS_UP);
    hit_mem = vs_hit(wr_addr, lane_cfg_pkg::OFS_VS_MEMBER);

    if (!s_r.loaded) begin
      if (s_r.init_cnt == lane_cfg_pkg::STRAP_CAPTURE_CNT) begin
        // Strap capture once the synchronisers hold the pin levels
        s_nxt.loaded   = 1'b1;
        s_nxt.port_cfg = 32'h0000_0000;
        s_nxt.port_cfg[lane_cfg_pkg::STN_CFG_LSB[0] +: 2] = s_r.strap_s2.stn0;
        s_nxt.port_cfg[lane_cfg_pkg::STN_CFG_LSB[1] +: 2] = s_r.strap_s2.stn5;
        s_nxt.port_cfg[lane_cfg_pkg::STN_CFG_LSB[2] +: 2] = s_r.strap_s2.stn4;
        s_nxt.member = lane_cfg_pkg::VS_MEMBER_DEF[s_r.strap_s2.vs];
        s_nxt.ups    = lane_cfg_pkg::VS_UP_DEF[s_r.strap_s2.vs];
      end else begin
        s_nxt.init_cnt = s_r.init_cnt + 2'h1;
      end
    end else if (wr_en) begin
      if (wr_addr == lane_cfg_pkg::OFS_PORT_CFG) begin
        s_nxt.port_cfg = wr_data & lane_cfg_pkg::PORT_CFG_MASK;
      end
      if (hit_up[2]) begin
        s_nxt.ups[hit_up[1:0]] = wr_data[lane_cfg_pkg::UP_FIELD_W-1:0];
      end
      if (hit_mem[2]) begin
        for (int j = 0; j < NV; j++) begin
          // A port joining one switch leaves all the others
          if (j == int'(hit_mem[1:0])) s_nxt.member[j] = wr_data[23:0];
          else s_nxt.member[j] = s_r.member[j] & ~wr_data[23:0];
        end
      end
    end

    s_nxt.rvalid = reg_rd;
    s_nxt.rdata  = reg_rd ? reg_read(s_r, reg_addr) : s_r.rdata;
    if (dev_assign_valid) s_nxt.up_dev = dev_assign_num;

    for (int k = 0; k < NP; k++) begin
      pn    = lane_cfg_pkg::port_num(k);
      is_up = 1'b0;
      in_vs = 1'b0;
      for (int j = 0; j < NV; j++) begin
        if (s_r.ups[j][8] && s_r.ups[j][4:0] == pn) is_up = 1'b1;
        if (s_r.member[j][pn]) in_vs = 1'b1;
      end
      s_nxt.en[k]   = map_en[k / 4][k % 4];
      s_nxt.vis[k]  = s_r.loaded && map_en[k / 4][k % 4] && in_vs;
      s_nxt.gen2[k] = tr_up[k] && s_r.g2_s2[k];
      s_nxt.dev[k]  = is_up ? s_r.up_dev : pn;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) s_r <= '0;
    else     s_r <= s_nxt;
  end

  // --------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------
  assign reg_rdata     = s_r.rdata;
  assign reg_rvalid    = s_r.rvalid;
  assign port_enable   = s_r.en;
  assign port_visible  = s_r.vis;
  assign link_up       = tr_up;
  assign link_width    = tr_w;
  assign lane_reversed = tr_rev;
  assign link_gen2     = s_r.gen2;
  assign dev_num       = s_r.dev;

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  logic       vs_overlap;
  logic       lane_gap;
  logic [5:0] stn_lanes [NS];

  always_comb begin
    vs_overlap = 1'b0;
    lane_gap   = 1'b0;
    for (int a = 0; a < NV; a++) begin
      for (int b = a + 1; b < NV; b++) begin
        if ((s_r.member[a] & s_r.member[b]) != 24'h000000) vs_overlap = 1'b1;
      end
    end
    for (int st = 0; st < NS; st++) begin
      stn_lanes[st] = 6'h00;
      for (int q = 0; q < 4; q++) begin
        stn_lanes[st] = stn_lanes[st] + 6'(map_w[st][q]);
        if (q > 0 && map_en[st][q] &&
            (6'(map_b[st][q]) != 6'(map_b[st][q-1]) + 6'(map_w[st][q-1]))) lane_gap = 1'b1;
      end
    end
  end

  one_switch_a: assert property (@(posedge clk) disable iff (rst)
    !vs_overlap)
    else $error("port belongs to two virtual switches");

  station_fit_a: assert property (@(posedge clk) disable iff (rst)
    stn_lanes[0] == 6'h10 && stn_lanes[1] == 6'h10 && stn_lanes[2] == 6'h10)
    else $error("station lanes not all handed out");

  lane_order_a: assert property (@(posedge clk) disable iff (rst)
    !lane_gap && map_b[0][0] == 4'h0 && map_b[1][0] == 4'h0 && map_b[2][0] == 4'h0)
    else $error("lanes not handed out in ascending order");

  cfg_write_a: assert property (@(posedge clk) disable iff (rst)
    (s_r.loaded && eeprom_wr && eeprom_addr == lane_cfg_pkg::OFS_PORT_CFG)
      |=> s_r.port_cfg == ($past(eeprom_wdata) & lane_cfg_pkg::PORT_CFG_MASK))
    else $error("EEPROM load did not replace port config");

  strap_load_a: assert property (@(posedge clk) disable iff (rst)
    $rose(s_r.loaded) && s_r.strap_s2.vs == 2'h1 && $past(s_r.strap_s2.vs) == 2'h1
      |-> s_r.member[0] == 24'h30000f && s_r.member[1] == 24'hcf0000
          && s_r.ups[1] == 9'h110)
    else $error("two-switch default not loaded");

  strap_port_a: assert property (@(posedge clk) disable iff (rst)
    $rose(s_r.loaded) |-> s_r.port_cfg[1:0] == $past(s_r.strap_s2.stn0)
      && s_r.port_cfg[9:8] == $past(s_r.strap_s2.stn4)
      && s_r.port_cfg[11:10] == $past(s_r.strap_s2.stn5))
    else $error("strap widths not captured");

  down_devnum_a: assert property (@(posedge clk) disable iff (rst)
    s_r.loaded && s_r.ups == $past(s_r.ups, 2) && s_r.ups[0][8] && s_r.ups[0][4:0] == 5'h00
      && s_r.ups[1][4:0] != 5'h01 && s_r.ups[2][4:0] != 5'h01 && s_r.ups[3][4:0] != 5'h01
      |=> dev_num[9:5] == 5'h01)
    else $error("downstream device number differs from port");

  up_devnum_a: assert property (@(posedge clk) disable iff (rst)
    dev_assign_valid && s_r.ups[0] == 9'h100 ##1 s_r.ups[0] == 9'h100
      |=> dev_num[4:0] == $past(dev_assign_num, 2))
    else $error("upstream bridge ignored assigned number");

  invisible_a: assert property (@(posedge clk) disable iff (rst)
    s_r.loaded && s_r.port_cfg[1:0] == 2'h1 && $past(s_r.port_cfg[1:0]) == 2'h1
      |=> port_visible[3:1] == 3'h0)
    else $error("disabled port visible");

  read_back_a: assert property (@(posedge clk) disable iff (rst)
    reg_rd && reg_addr == lane_cfg_pkg::OFS_PORT_CFG && !reg_wr && !eeprom_wr
      |=> reg_rvalid && reg_rdata == $past(s_r.port_cfg))
    else $error("config read returned wrong value");

  speed_a: assert property (@(posedge clk) disable iff (rst)
    link_gen2[0] |-> $past(link_up[0]) && $past(s_r.g2_s2[0]))
    else $error("Gen 2 without capable linked port");

endmodule : switch_port_lane_config

// [lane_cfg_pkg.sv]
// Notes on behaviour
// - Forty-eight lanes form three stations of sixteen lanes, one serializer per lane.
// - A station forms one to four ports, never using another station's lanes.
// - Stations split independently; unconfigured or disabled ports stay invisible.
// - Straps set initial widths; EEPROM load after reset replaces them.
// - An external host may rewrite port configuration through the management port.
// - Training narrows width to the smaller of the two ports' widths.
// - Broken lanes are dropped; x16 falls back to x8, x4, x2 or x1.
// - Failing even at x1, the port reverses lane order and trains again.
// - Each port runs Gen 1 or Gen 2 independently of the others.
// - Station 0 code in bits 1:0: 00 4x4, 01 x16, 10 2x8, 11 x8+2x4.
// - Station 5 code in bits 11:10 splits lanes 16-31 over ports 20-23.
// - Station 4 code in bits 9:8 splits lanes 32-47 over ports 16-19.
// - Lanes go out ascending; the lowest enabled port takes the lowest lanes.
// - Membership vectors at 380h-38Ch; each port belongs to one virtual switch.
// - Upstream selects at 360h-36Ch; at most one upstream per virtual switch.
// - Count strap LH: port 0 and port 16 each lead five downstream ports.
// - HL: 0, 16, 20 lead their stations; HH: four switches as tabled.
// - A downstream bridge reports device number equal to its port number.
// - The upstream bridge adopts the device number its upstream device assigns.
// - Any port may be made upstream, at load time or later.
// - Ports 0-3, 16-19, 20-23 per station; each four lanes form quads 0-3.
package lane_cfg_pkg;

  localparam int STATIONS      = 3;
  localparam int PORTS_PER_STN = 4;
  localparam int LANES_PER_STN = 16;
  localparam int NUM_PORTS     = 12;
  localparam int NUM_VS        = 4;
  localparam int PORT_VEC_W    = 24;

  localparam logic [11:0] OFS_PORT_CFG  = 12'h300;
  localparam logic [11:0] OFS_VS_UP     = 12'h360;
  localparam logic [11:0] OFS_VS_MEMBER = 12'h380;
  localparam logic [31:0] PORT_CFG_MASK = 32'h0000_0f03;
  localparam int          STN_CFG_LSB [STATIONS] = '{0, 10, 8};
  localparam int          UP_FIELD_W    = 9;
  localparam logic [1:0]  STRAP_CAPTURE_CNT = 2'h2;

  // Station slot 0 is station 0, slot 1 station 5, slot 2 station 4
  localparam logic [2:0][4:0] STN_PORT_BASE = {5'h10, 5'h14, 5'h00};

  // Lane split per width code, indexed [code][port within station]
  localparam logic [3:0][3:0][4:0] MAP_WIDTH = {
    {5'h00, 5'h04, 5'h04, 5'h08}, {5'h00, 5'h00, 5'h08, 5'h08},
    {5'h00, 5'h00, 5'h00, 5'h10}, {5'h04, 5'h04, 5'h04, 5'h04}};
  localparam logic [3:0][3:0][3:0] MAP_BASE = {
    {4'h0, 4'hc, 4'h8, 4'h0}, {4'h0, 4'h0, 4'h8, 4'h0},
    {4'h0, 4'h0, 4'h0, 4'h0}, {4'hc, 4'h8, 4'h4, 4'h0}};

  // Virtual switch defaults, indexed [count strap][switch]
  localparam logic [3:0][3:0][23:0] VS_MEMBER_DEF = {
    {24'hc80000, 24'h340000, 24'h030008, 24'h000007},
    {24'h000000, 24'hf00000, 24'h0f0000, 24'h00000f},
    {24'h000000, 24'h000000, 24'hcf0000, 24'h30000f},
    {24'h000000, 24'h000000, 24'h000000, 24'hff000f}};
  // Upstream select: bit 8 valid, bits 4:0 port number
  localparam logic [3:0][3:0][8:0] VS_UP_DEF = {
    {9'h116, 9'h114, 9'h110, 9'h100}, {9'h000, 9'h114, 9'h110, 9'h100},
    {9'h000, 9'h000, 9'h110, 9'h100}, {9'h000, 9'h000, 9'h000, 9'h100}};

  typedef struct packed {
    logic [1:0] vs;
    logic [1:0] stn5;
    logic [1:0] stn4;
    logic [1:0] stn0;
  } strap_t;

  typedef enum logic [1:0] {T_IDLE, T_PROBE, T_UP, T_FAIL} train_state_t;

  function automatic logic [4:0] port_num(input int k);
    port_num = STN_PORT_BASE[k / PORTS_PER_STN] + 5'(k % PORTS_PER_STN);
  endfunction : port_num

  function automatic logic [4:0] pow2_floor(input logic [4:0] v);
    if (v[4])      pow2_floor = 5'h10;
    else if (v[3]) pow2_floor = 5'h08;
    else if (v[2]) pow2_floor = 5'h04;
    else if (v[1]) pow2_floor = 5'h02;
    else           pow2_floor = v;
  endfunction : pow2_floor

endpackage : lane_cfg_pkg

// [lane_map_if.sv]
`timescale 1ns/1ps
interface lane_map_if;
  logic [1:0]      code;
  logic [3:0]      en;
  logic [3:0][4:0] width;
  logic [3:0][3:0] base;
  modport map  (input code, output en, width, base);
  modport user (output code, input en, width, base);
endinterface : lane_map_if

// [station_lane_map.sv]
`timescale 1ns/1ps
module station_lane_map (
  // Width code in, lane split out
  lane_map_if.map bus
);

  // --------------------------------------------------------------
  // Lane split
  // --------------------------------------------------------------
  always_comb begin
    for (int q = 0; q < lane_cfg_pkg::PORTS_PER_STN; q++) begin
      bus.width[q] = lane_cfg_pkg::MAP_WIDTH[bus.code][q];
      bus.base[q]  = lane_cfg_pkg::MAP_BASE[bus.code][q];
      bus.en[q]    = (lane_cfg_pkg::MAP_WIDTH[bus.code][q] != 5'h00);
    end
  end

endmodule : station_lane_map

// [port_link_trainer.sv]
`timescale 1ns/1ps
module port_link_trainer (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Control
  input  wire logic       enable,
  input  wire logic       start,
  input  wire logic [4:0] prog_width,
  input  wire logic [4:0] partner_width,
  input  wire logic [15:0] lanes,
  // Result
  output logic            link_up,
  output logic [4:0]      link_width,
  output logic            reversed
);

  typedef struct packed {
    lane_cfg_pkg::train_state_t st;
    logic [4:0]                 w;
    logic                       rev;
  } train_t;

  train_t      s_r;
  train_t      s_nxt;
  logic [16:0] ones;
  logic [15:0] win;
  logic [4:0]  start_w;
  logic        win_ok;

  always_comb begin
    s_nxt   = s_r;
    start_w = lane_cfg_pkg::pow2_floor((partner_width < prog_width) ? partner_width
                                                                   : prog_width);
    ones    = (17'h00001 << s_r.w) - 17'h00001;
    win     = s_r.rev ? (ones[15:0] << (prog_width - s_r.w)) : ones[15:0];
    win_ok  = ((lanes & win) == win) && (s_r.w != 5'h00);
    case (s_r.st)
      lane_cfg_pkg::T_IDLE: begin
        if (enable && start) begin
          s_nxt.w   = start_w;
          s_nxt.rev = 1'b0;
          s_nxt.st  = lane_cfg_pkg::T_PROBE;
        end
      end
      lane_cfg_pkg::T_PROBE: begin
        if (!enable) begin
          s_nxt.st = lane_cfg_pkg::T_IDLE;
        end else if (win_ok) begin
          s_nxt.st = lane_cfg_pkg::T_UP;
        end else if (s_r.w > 5'h01) begin
          s_nxt.w = s_r.w >> 1;
        end else if (!s_r.rev) begin
          s_nxt.rev = 1'b1;
          s_nxt.w   = start_w;
        end else begin
          s_nxt.st = lane_cfg_pkg::T_FAIL;
        end
      end
      lane_cfg_pkg::T_UP, lane_cfg_pkg::T_FAIL: begin
        if (!enable || !start) s_nxt.st = lane_cfg_pkg::T_IDLE;
      end
      default: s_nxt.st = lane_cfg_pkg::T_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) s_r <= '{st: lane_cfg_pkg::T_IDLE, w: 5'h00, rev: 1'b0};
    else     s_r <= s_nxt;
  end

  assign link_up    = (s_r.st == lane_cfg_pkg::T_UP);
  assign link_width = link_up ? s_r.w : 5'h00;
  assign reversed   = s_r.rev;

  width_cap_a: assert property (@(posedge clk) disable iff (rst)
    $rose(link_up) |-> (link_width <= $past(prog_width)) && (link_width <= $past(partner_width)))
    else $error("link width above the narrower port");
  halve_step_a: assert property (@(posedge clk) disable iff (rst)
    (s_r.st == lane_cfg_pkg::T_PROBE && enable && !win_ok && s_r.w > 5'h01)
      |=> s_r.w == ($past(s_r.w) >> 1))
    else $error("failed width did not halve");
  reverse_x1_a: assert property (@(posedge clk) disable iff (rst)
    $rose(s_r.rev) |-> $past(s_r.w) <= 5'h01 && $past(s_r.st) == lane_cfg_pkg::T_PROBE)
    else $error("lane reversal before x1 failure");

endmodule : port_link_trainer

// [link_partner.sv]
`timescale 1ns/1ps
module link_partner (
  // Setup from the bench
  input  wire logic [4:0] width,
  input  wire logic [5:0] bad,
  input  wire logic       g2,
  // Pins toward the switch
  output logic [47:0] lane_ok,
  output logic [59:0] partner_width,
  output logic [11:0] gen2_capable
);
  always_comb begin
    lane_ok = '1;
    if (bad < 6'd48) lane_ok[bad] = 1'b0;
    partner_width = {12{width}};
    gen2_capable = {12{g2}};
  end
endmodule : link_partner

// [testbench.sv]
`timescale 1ns/1ps
module testbench;
  logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, ew = 1'b0, dv = 1'b0, g2 = 1'b0;
  logic [1:0]  st0 = 2'h0, st4 = 2'h0, st5 = 2'h0, vsm = 2'h0;
  logic [11:0] addr = 12'h0, eaddr = 12'h0, treq = 12'h0;
  logic [31:0] wd = 32'h0, ed = 32'h0, rdat, lf = 32'h374d5a8b;
  logic [4:0]  pw = 5'h10, dan = 5'h0;
  logic [5:0]  bad = 6'h3f;
  logic [47:0] lok;
  logic [59:0] pwid, lw, dn;
  logic [11:0] g2c, en, vis, up, rev, lg2;
  logic        rv;
  int          error_cnt = 0, num_checks = 0;
  // Expected switch defaults for count straps LH, HL, HH
  logic [3:0][23:0] vm [1:3] = '{{24'h000000, 24'h000000, 24'hcf0000, 24'h30000f},
    {24'h000000, 24'hf00000, 24'h0f0000, 24'h00000f},
    {24'hc80000, 24'h340000, 24'h030008, 24'h000007}};
  logic [3:0][8:0]  vu [1:3] = '{{9'h000, 9'h000, 9'h110, 9'h100},
    {9'h000, 9'h114, 9'h110, 9'h100}, {9'h116, 9'h114, 9'h110, 9'h100}};
  always #5 clk = ~clk;
  link_partner pm_u (.width(pw), .bad(bad), .g2(g2), .lane_ok(lok), .partner_width(pwid),
    .gen2_capable(g2c));
  switch_port_lane_config dut_u (.clk(clk), .rst(rst), .station0_width_strap(st0),
    .station4_width_strap(st4), .station5_width_strap(st5), .vswitch_count_strap(vsm),
    .reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wd), .reg_rdata(rdat),
    .reg_rvalid(rv), .eeprom_wr(ew), .eeprom_addr(eaddr), .eeprom_wdata(ed),
    .lane_ok(lok), .partner_width(pwid), .train_req(treq), .gen2_capable(g2c),
    .dev_assign_valid(dv), .dev_assign_num(dan), .port_enable(en), .port_visible(vis),
    .link_up(up), .link_width(lw), .lane_reversed(rev), .link_gen2(lg2), .dev_num(dn));
  // ----------------------------------------
  // Reference model and bus tasks
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf;
  endfunction : rnd
  function automatic logic [3:0] en_of(logic [1:0] c);
    return (c == 2'h0) ? 4'hf : (c == 2'h1) ? 4'h1 : (c == 2'h2) ? 4'h3 : 4'h7;
  endfunction : en_of
  // Widths halve from the common width, then the reversed window is tried
  function automatic int exp_w(int p, int b, output bit r);
    int w;
    w = (p < 16) ? p : 16;
    while (w & (w - 1)) w = w & (w - 1);
    for (int k = 0; k < 2; k++) begin
      for (int v = w; v > 0; v = v / 2) begin
        r = k;
        if (b < (k ? 16 - v : 0) || b >= (k ? 16 : v)) return v;
      end
    end
    r = 0;
    return 0;
  endfunction : exp_w
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // With e set the loader writes d while the host writes its inverse
  task automatic wrt(logic [11:0] a, logic [31:0] d, bit e);
    @(negedge clk);
    {ew, eaddr, ed} = {e, a, d};
    {wr, addr, wd} = {1'b1, a, e ? ~d : d};
    @(negedge clk);
    {wr, ew} = 2'b00;
  endtask : wrt
  task automatic rdr(logic [11:0] a, logic [31:0] e);
    int n;
    @(negedge clk);
    {rd, addr} = {1'b1, a};
    @(negedge clk);
    rd = 1'b0;
    for (n = 0; n < 4 && rv !== 1'b1; n++) @(negedge clk);
    if (n == 4) error_cnt++;
    if (n == 4) report_and_stop();
    chk("reg_rdata", rdat, e);
  endtask : rdr
  initial begin
    int tp[5] = '{16, 4, 16, 16, 0};
    int tb[5] = '{63, 63, 12, 0, 63};
    int w, n;
    bit r;
    {st0, st4, st5} = 6'(rnd());
    repeat (8) @(negedge clk);
    rst = 1'b0;
    repeat (6) @(negedge clk);
    chk("port_enable", en, {en_of(st4), en_of(st5), en_of(st0)});
    rdr(12'h300, {20'h0, st5, st4, 6'h0, st0});
    $display("test straps done");
    for (int c = 0; c < 4; c++) begin
      wrt(12'h300, {20'h0, 2'(c + 1), 2'(c + 2), 6'h0, 2'(c)}, 1'b0);
      repeat (2) @(negedge clk);
      chk("port_enable", en, {en_of(2'(c + 2)), en_of(2'(c + 1)), en_of(2'(c))});
      chk("port_visible", vis, {en_of(2'(c + 2)), en_of(2'(c + 1)), en_of(2'(c))});
    end
    wrt(12'h300, 32'hffffffff, 1'b0);
    rdr(12'h300, 32'h00000f03);
    wrt(12'h300, 32'h1, 1'b1);
    rdr(12'h300, 32'h1);
    rdr(12'h3f0, 32'h0);
    $display("test width codes done");
    for (int i = 0; i < 5; i++) begin
      {pw, bad, g2} = {5'(tp[i]), 6'(tb[i]), 1'(rnd())};
      w = exp_w(tp[i], tb[i], r);
      repeat (3) @(negedge clk);
      treq[0] = 1'b1;
      for (n = 0; n < 60 && up[0] !== 1'b1; n++) @(negedge clk);
      if (n == 60 && w > 0) error_cnt++;
      if (n == 60 && w > 0) report_and_stop();
      @(negedge clk);
      chk("link_up", up[0], w > 0);
      if (w > 0) begin
        chk("link_width", lw[4:0], w);
        chk("lane_reversed", rev[0], r);
        chk("link_gen2", lg2[0], g2);
      end
      treq[0] = 1'b0;
      repeat (4) @(negedge clk);
    end
    $display("test training done");
    wrt(12'h300, 32'h0, 1'b0);
    @(negedge clk);
    {dv, dan} = {1'b1, 5'(rnd())};
    @(negedge clk);
    dv = 1'b0;
    wrt(12'h384, 32'h2, 1'b0);
    rdr(12'h380, 32'h00ff000d);
    wrt(12'h364, 32'h101, 1'b0);
    rdr(12'h364, 32'h101);
    repeat (2) @(negedge clk);
    chk("dev_num", dn[9:5], dan);
    chk("dev_num", dn[24:20], 5'h14);
    chk("port_visible", vis, 12'hfff);
    $display("test switches done");
    for (int v = 1; v < 4; v++) begin
      @(negedge clk);
      {rst, vsm} = {1'b1, 2'(v)};
      repeat (8) @(negedge clk);
      rst = 1'b0;
      repeat (6) @(negedge clk);
      for (int j = 0; j < 4; j++) begin
        rdr(12'(12'h380 + 4 * j), {8'h00, vm[v][j]});
        rdr(12'(12'h360 + 4 * j), {23'h0, vu[v][j]});
      end
      chk("port_visible", vis, {en_of(st4), en_of(st5), en_of(st0)});
      chk("dev_num", dn[9:5], 5'h01);
      chk("dev_num", dn[44:40], 5'h00);
    end
    $display("test switch modes done");
    report_and_stop();
  end
endmodule : testbench
